// [include/nvh_consts.vh]
// timing and sequencing constants for the nonvolatile sram host port
`ifndef NVH_CONSTS_VH
`define NVH_CONSTS_VH
`define NVH_CLK_NS          50
`define NVH_T_CYCLE_NS      25
`define NVH_T_PWE_NS        20
`define NVH_T_PHSB_NS       15
`define NVH_T_ZZL_NS        50
`define NVH_T_DHSB_NS       25
`define NVH_T_STORE_MS      8
`define NVH_T_RECALL_US     600
`define NVH_T_SS_US         500
`define NVH_T_WAKE_MS       30
`define NVH_T_SLEEP_MS      8
`define NVH_T_HRECALL_MS    30
`define NVH_SEQ_LEN         6
`define NVH_OP_READ         3'h0
`define NVH_OP_WRITE        3'h1
`define NVH_OP_SW_SEQ       3'h2
`define NVH_OP_HW_STORE     3'h3
`define NVH_OP_SLEEP        3'h4
`define NVH_OP_WAKE         3'h5
`endif

// [logic/nvh_timer.v]
// down counter that reports when a loaded wait has run out
`timescale 1ns/100ps
module nvh_timer #(
    parameter W = 24
) (
    input  wire         clk,
    input  wire         reset,
    input  wire         clk_en,
    input  wire         load,
    input  wire [W-1:0] value,
    output reg          done
);
    reg [W-1:0] count;

    // done goes high on the cycle the count reaches zero
    always @(posedge clk) begin
        if (reset) begin
            count <= {W{1'b0}};
            done  <= 1'b0;
        end else if (clk_en) begin
            if (load) begin
                count <= value;
                done  <= 1'b0;
            end else if (count != {W{1'b0}}) begin
                count <= count - {{(W-1){1'b0}}, 1'b1};
                done  <= (count == {{(W-1){1'b0}}, 1'b1});
            end else begin
                done  <= 1'b0;
            end
        end
    end
endmodule // nvh_timer

// [logic/nvh_host_port.v]
// host controller driving the pins of a nonvolatile sram
// What this block does
// - write strobe stays high through every read cycle the host issues.
// - store/busy pin is released during every ordinary read or write.
// - writes are issued only as select-controlled cycles, write strobe falling with select.
// - low-byte enable falls before select and strobe on every write that uses the low byte.
// - command sequence is sent as select-controlled read cycles.
// - six command addresses are read in order with strobe held high.
// - hardware store request drives store/busy low at least 15 ns.
// - after raising sleep request the host waits 30 ms before access.
// - sleep request low at least 50 ns; entry takes up to 8 ms.
`timescale 1ns/100ps
`include "nvh_consts.vh"
module nvh_host_port #(
    parameter AW         = 20,
    parameter DW         = 16,
    parameter STORE_CYC  = 160000,
    parameter RECALL_CYC = 12000,
    parameter SS_CYC     = 10000,
    parameter WAKE_CYC   = 600000,
    parameter SLEEP_CYC  = 160000,
    parameter PWRUP_CYC  = 600000
) (
    input  wire          clk,
    input  wire          reset,
    input  wire          clk_en,
    input  wire          req_valid,
    input  wire [2:0]    req_op,
    input  wire [AW-1:0] req_addr,
    input  wire [DW-1:0] req_wdata,
    input  wire [1:0]    req_lanes,
    input  wire [AW*6-1:0] seq_addrs,
    output reg           req_ready,
    output reg           rsp_valid,
    output reg  [DW-1:0] rsp_rdata,
    output reg           rsp_data_ok,
    output reg           select_low_input,
    output reg           select_high_input,
    output reg           write_n,
    output reg           out_en_n,
    output reg           low_byte_strobe_n,
    output reg           high_byte_strobe_n,
    output reg  [AW-1:0] addr,
    output reg  [DW-1:0] dq_out,
    output reg           dq_oe,
    input  wire [DW-1:0] dq_in,
    output reg           hw_store_busy_n_out,
    output reg           hw_store_busy_n_oe,
    input  wire          hw_store_busy_n_in,
    output reg           sleep_request_n,
    output reg           sleeping
);
    // ********************************************************************
    // states and derived counts
    // ********************************************************************
    localparam S_PWRUP = 4'h0;
    localparam S_IDLE  = 4'h1;
    localparam S_SETUP = 4'h2;
    localparam S_STRB  = 4'h3;
    localparam S_END   = 4'h4;
    localparam S_WAIT  = 4'h5;
    localparam S_HWS   = 4'h6;
    localparam S_BUSY  = 4'h7;
    localparam S_SLEEP = 4'h8;
    localparam S_ZZ    = 4'h9;
    // strobe pulses are one 50 ns cycle and the store pulse three, which covers 15, 20, 25 and 50 ns minima
    localparam [23:0] PULSE_CYC = 24'h0000_0001;

    reg  [3:0]    state;
    reg  [2:0]    op;
    reg  [2:0]    seq_idx;
    reg           tmr_load;
    reg  [23:0]   tmr_value;
    wire          tmr_done;
    reg           busy_seen;

    nvh_timer #(.W(24)) u_timer (
        .clk    (clk),
        .reset  (reset),
        .clk_en (clk_en),
        .load   (tmr_load),
        .value  (tmr_value),
        .done   (tmr_done)
    );

    // ********************************************************************
    // sequencer
    // ********************************************************************
    // one-state-per-edge sequencing keeps every pin change on its own clock
    always @(posedge clk) begin
        if (reset) begin
            state               <= S_PWRUP;
            op                  <= `NVH_OP_READ;
            seq_idx             <= 3'h0;
            tmr_load            <= 1'b1;
            tmr_value           <= PWRUP_CYC[23:0];
            busy_seen           <= 1'b0;
            req_ready           <= 1'b0;
            rsp_valid           <= 1'b0;
            rsp_rdata           <= {DW{1'b0}};
            rsp_data_ok         <= 1'b0;
            select_low_input    <= 1'b1;
            select_high_input   <= 1'b0;
            write_n             <= 1'b1;
            out_en_n            <= 1'b1;
            low_byte_strobe_n   <= 1'b1;
            high_byte_strobe_n  <= 1'b1;
            addr                <= {AW{1'b0}};
            dq_out              <= {DW{1'b0}};
            dq_oe               <= 1'b0;
            hw_store_busy_n_out <= 1'b1;
            hw_store_busy_n_oe  <= 1'b0;
            sleep_request_n     <= 1'b1;
            sleeping            <= 1'b0;
        end else if (clk_en) begin
            tmr_load  <= 1'b0;
            rsp_valid <= 1'b0;
            case (state)
                S_PWRUP: begin
                    // wait out the power-up recall before any access
                    if (tmr_done) begin
                        state     <= S_IDLE;
                        req_ready <= 1'b1;
                    end
                end
                S_IDLE: begin
                    if (req_valid) begin
                        req_ready <= 1'b0;
                        op        <= req_op;
                        addr      <= (req_op == `NVH_OP_SW_SEQ) ? seq_addrs[AW-1:0] : req_addr;
                        seq_idx   <= 3'h0;
                        case (req_op)
                            `NVH_OP_READ, `NVH_OP_WRITE, `NVH_OP_SW_SEQ: begin
                                // address and lanes settle with select and strobe high
                                hw_store_busy_n_oe <= 1'b0;
                                write_n            <= 1'b1;
                                low_byte_strobe_n  <= ~(req_lanes[0] | (req_op != `NVH_OP_WRITE));
                                high_byte_strobe_n <= ~(req_lanes[1] | (req_op != `NVH_OP_WRITE));
                                dq_out             <= req_wdata;
                                dq_oe              <= (req_op == `NVH_OP_WRITE);
                                state              <= S_SETUP;
                            end
                            `NVH_OP_HW_STORE: begin
                                hw_store_busy_n_out <= 1'b0;
                                hw_store_busy_n_oe  <= 1'b1;
                                tmr_load            <= 1'b1;
                                tmr_value           <= PULSE_CYC;
                                state               <= S_HWS;
                            end
                            `NVH_OP_SLEEP: begin
                                sleep_request_n <= 1'b0;
                                tmr_load        <= 1'b1;
                                tmr_value       <= SLEEP_CYC[23:0];
                                state           <= S_SLEEP;
                            end
                            `NVH_OP_WAKE: begin
                                sleep_request_n <= 1'b1;
                                tmr_load        <= 1'b1;
                                tmr_value       <= WAKE_CYC[23:0];
                                state           <= S_ZZ;
                            end
                            default: begin
                                req_ready <= 1'b1;
                                rsp_valid <= 1'b1;
                            end
                        endcase
                    end
                end
                S_SETUP: begin
                    // select-controlled cycle: select and strobe fall on the same edge
                    select_low_input  <= 1'b0;
                    select_high_input <= 1'b1;
                    if (op == `NVH_OP_WRITE) begin
                        write_n <= 1'b0;
                    end else begin
                        out_en_n <= 1'b0;
                    end
                    state <= S_STRB;
                end
                S_STRB: begin
                    // one 50 ns low phase covers the 20 ns pulse and 25 ns cycle
                    select_low_input  <= 1'b1;
                    select_high_input <= 1'b0;
                    write_n           <= 1'b1;
                    out_en_n          <= 1'b1;
                    rsp_rdata         <= dq_in;
                    // the sixth command read carries no usable data
                    rsp_data_ok       <= (op == `NVH_OP_READ);
                    state             <= S_END;
                end
                S_END: begin
                    dq_oe              <= 1'b0;
                    low_byte_strobe_n  <= 1'b1;
                    high_byte_strobe_n <= 1'b1;
                    if (op == `NVH_OP_SW_SEQ && seq_idx != (`NVH_SEQ_LEN - 1)) begin
                        seq_idx            <= seq_idx + 3'h1;
                        addr               <= seq_addrs[(seq_idx + 3'h1) * AW +: AW];
                        low_byte_strobe_n  <= 1'b0;
                        high_byte_strobe_n <= 1'b0;
                        state              <= S_SETUP;
                    end else if (op == `NVH_OP_SW_SEQ) begin
                        // give the command time to act, then the recall/store span
                        tmr_load  <= 1'b1;
                        tmr_value <= SS_CYC[23:0] + RECALL_CYC[23:0];
                        state     <= S_WAIT;
                    end else begin
                        rsp_valid <= 1'b1;
                        req_ready <= 1'b1;
                        state     <= S_IDLE;
                    end
                end
                S_HWS: begin
                    if (tmr_done) begin
                        // release the pin; the device may now hold it low
                        hw_store_busy_n_out <= 1'b1;
                        hw_store_busy_n_oe  <= 1'b0;
                        busy_seen           <= 1'b0;
                        tmr_load            <= 1'b1;
                        tmr_value           <= STORE_CYC[23:0];
                        state               <= S_BUSY;
                    end
                end
                S_BUSY: begin
                    // a skipped store releases within 25 ns, so one high sample ends it
                    if (!hw_store_busy_n_in) begin
                        busy_seen <= 1'b1;
                    end
                    if (hw_store_busy_n_in || tmr_done) begin
                        rsp_valid <= 1'b1;
                        req_ready <= 1'b1;
                        state     <= S_IDLE;
                    end
                end
                S_WAIT: begin
                    if (tmr_done) begin
                        rsp_valid <= 1'b1;
                        req_ready <= 1'b1;
                        state     <= S_IDLE;
                    end
                end
                S_SLEEP: begin
                    // select is ignored once entry completes
                    if (tmr_done) begin
                        sleeping  <= 1'b1;
                        rsp_valid <= 1'b1;
                        req_ready <= 1'b1;
                        state     <= S_IDLE;
                    end
                end
                S_ZZ: begin
                    // no access until the wake time has passed
                    if (tmr_done) begin
                        sleeping  <= 1'b0;
                        rsp_valid <= 1'b1;
                        req_ready <= 1'b1;
                        state     <= S_IDLE;
                    end
                end
                default: begin
                    state     <= S_IDLE;
                    req_ready <= 1'b1;
                end
            endcase
        end
    end
    // write strobe falls with select and output enable stays high on writes, so outputs never fight
endmodule // nvh_host_port

// [tb/nvh_host_port_monitor.sv]
// assertion checker on the pins of the nonvolatile sram host port
`timescale 1ns/100ps
`include "nvh_consts.vh"
module nvh_host_port_monitor (
    input wire       clk,
    input wire       reset,
    input wire       clk_en,
    input wire       req_valid,
    input wire [2:0] req_op,
    input wire       req_ready,
    input wire       rsp_valid,
    input wire       select_low_input,
    input wire       select_high_input,
    input wire       write_n,
    input wire       out_en_n,
    input wire       low_byte_strobe_n,
    input wire       hw_store_busy_n_out,
    input wire       hw_store_busy_n_oe,
    input wire       sleep_request_n,
    input wire       sleeping
);
    // ****
    // pin sequencing checks
    // ****
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    // the device only counts as selected with both selects active
    wire sel  = !select_low_input && select_high_input;
    wire take = clk_en && req_valid && req_ready;
    a_read_we_high: assert property (sel && !out_en_n |-> write_n)
        else $error("write strobe low during a read");
    a_busy_free: assert property (sel |-> !hw_store_busy_n_oe)
        else $error("store pin driven during an access");
    a_write_sel_ctl: assert property ($fell(write_n) |-> $fell(select_low_input) && sel)
        else $error("write strobe not paired with select");
    a_write_end: assert property ($rose(write_n) |-> $rose(select_low_input))
        else $error("write strobe ended apart from select");
    a_lane_first: assert property (
        $fell(select_low_input) && !low_byte_strobe_n |-> !$past(low_byte_strobe_n))
        else $error("low byte enable fell with select");
    a_read_walk: assert property (
        take && req_op == `NVH_OP_READ |=> ##1 (sel && !out_en_n) ##1 (!sel && out_en_n)
        ##1 (rsp_valid && req_ready))
        else $error("read cycle out of step");
    a_seq_we_high: assert property (take && req_op == `NVH_OP_SW_SEQ |=> write_n[*8])
        else $error("write strobe low in command sequence");
    a_store_pulse: assert property (
        $rose(hw_store_busy_n_oe) |-> (hw_store_busy_n_oe && !hw_store_busy_n_out)[*3]
        ##1 !hw_store_busy_n_oe)
        else $error("store request pulse wrong length");
    a_sleep_hold: assert property ($fell(sleep_request_n) |=> !sleep_request_n)
        else $error("sleep request too short");
    a_sleep_quiet: assert property (sleeping |-> select_low_input)
        else $error("select while asleep");
    c_seq: cover property (take && req_op == `NVH_OP_SW_SEQ);
    c_store: cover property ($rose(hw_store_busy_n_oe));
    c_sleep: cover property ($rose(sleeping));
endmodule // nvh_host_port_monitor

bind nvh_host_port nvh_host_port_monitor u_mon (
    .clk(clk), .reset(reset), .clk_en(clk_en), .req_valid(req_valid), .req_op(req_op),
    .req_ready(req_ready), .rsp_valid(rsp_valid), .select_low_input(select_low_input),
    .select_high_input(select_high_input), .write_n(write_n), .out_en_n(out_en_n),
    .low_byte_strobe_n(low_byte_strobe_n), .hw_store_busy_n_out(hw_store_busy_n_out),
    .hw_store_busy_n_oe(hw_store_busy_n_oe), .sleep_request_n(sleep_request_n),
    .sleeping(sleeping));

// [tb/nvh_sram_model.sv]
// pin level model of the nonvolatile sram behind the host port
`timescale 1ns/100ps
module nvh_sram_model #(
    parameter       AW   = 20,
    parameter       DW   = 16,
    parameter [7:0] ST_N = 8'h0C,
    parameter [7:0] RC_N = 8'h0A
) (
    input  wire            clk,
    input  wire            reset,
    input  wire            select_low_input,
    input  wire            select_high_input,
    input  wire            write_n,
    input  wire            out_en_n,
    input  wire            low_byte_strobe_n,
    input  wire            high_byte_strobe_n,
    input  wire [AW-1:0]   addr,
    input  wire [DW-1:0]   dq_out,
    input  wire [AW*6-1:0] seq_addrs,
    input  wire            hw_store_busy_n,
    input  wire            sleep_request_n,
    output wire [DW-1:0]   dq_in,
    output wire            dev_busy
);
    // ****
    // storage and nonvolatile cycles
    // ****
    reg [DW-1:0] mem [0:15];
    reg [DW-1:0] junk;
    reg [7:0]    bcnt;
    reg [2:0]    nseq;
    reg          dirty;
    reg          asleep;
    wire sel  = !select_low_input && select_high_input && !asleep;
    wire lock = bcnt != 8'h00;
    wire rd   = sel && write_n && !out_en_n && !lock;
    // the closing command read drives nothing usable, so the host must not trust it
    wire last = (nseq == 3'h5) && (addr == seq_addrs[5*AW +: AW]);
    assign dev_busy = lock;
    // an undriven lane toggles every cycle so a stale value never passes
    assign dq_in[7:0]    = (rd && !last && !low_byte_strobe_n) ? mem[addr[3:0]][7:0]
                                                                : junk[7:0];
    assign dq_in[DW-1:8] = (rd && !last && !high_byte_strobe_n) ? mem[addr[3:0]][DW-1:8]
                                                                 : junk[DW-1:8];
    always @(posedge clk) begin
        junk <= ~junk;
        if (reset) begin
            junk   <= 16'h5A3C;
            bcnt   <= 8'h04; // short power-up recall
            nseq   <= 3'h0;
            dirty  <= 1'b0;
            asleep <= 1'b0;
        end else begin
            asleep <= !sleep_request_n;
            if (lock) begin
                bcnt <= bcnt - 8'h01;
            end else if (!hw_store_busy_n && dirty) begin
                // a store with nothing written since the last one is skipped
                bcnt  <= ST_N;
                dirty <= 1'b0;
            end
            if (sel && !write_n && !lock) begin
                if (!low_byte_strobe_n) mem[addr[3:0]][7:0] <= dq_out[7:0];
                if (!high_byte_strobe_n) mem[addr[3:0]][DW-1:8] <= dq_out[DW-1:8];
                dirty <= 1'b1;
                nseq  <= 3'h0;
            end
            if (rd) begin
                if (addr != seq_addrs[nseq*AW +: AW]) nseq <= 3'h0;
                else if (nseq == 3'h5) begin
                    nseq <= 3'h0;
                    bcnt <= RC_N;
                end else nseq <= nseq + 3'h1;
            end
        end
    end
endmodule // nvh_sram_model

// [tb/nvh_host_port_bench.sv]
// self-checking bench for the nonvolatile sram host port
`timescale 1ns/100ps
`include "nvh_consts.vh"
module nvh_host_port_bench;
    // ****
    // clock, reset, design and device model
    // ****
    // command address table, entry 0 in the low bits
    reg [119:0] seq_tab = {20'h0_0060, 20'h0_0050, 20'h0_0040, 20'h0_0030, 20'h0_0020,
                           20'h0_0010};
    reg         clk = 1'b0;
    reg         clk_en = 1'b1;
    reg         reset = 1'b1;
    reg         req_valid = 1'b0;
    reg  [2:0]  req_op = 3'h0;
    reg  [19:0] req_addr = 20'h0_0000;
    reg  [15:0] req_wdata = 16'h0000;
    reg  [1:0]  req_lanes = 2'h0;
    integer     cyc, tick = 0, n_mismatch = 0, checks_done = 0, lock_cyc = 0;
    wire        req_ready, rsp_valid, rsp_data_ok, sleeping, dev_busy, dq_oe;
    wire        sel_lo, sel_hi, wr_n, rd_en_n, lo_n, hi_n, bsy_out, bsy_oe, slp_n;
    wire [15:0] rdata, dq_o, dq_i;
    wire [19:0] pin_addr;
    // store pin is pulled up: low while either party pulls it
    wire        bsy_n = !(bsy_oe && !bsy_out) && !dev_busy;
    always #25 clk = ~clk;
    // cycles the device has spent locked, read as a before/after difference
    always @(posedge clk) if (dev_busy) lock_cyc <= lock_cyc + 1;
    nvh_host_port #(.STORE_CYC(20), .RECALL_CYC(12), .SS_CYC(10), .WAKE_CYC(16),
        .SLEEP_CYC(14), .PWRUP_CYC(8)) i_dut (.clk(clk), .reset(reset), .clk_en(clk_en),
        .req_valid(req_valid), .req_op(req_op), .req_addr(req_addr), .req_wdata(req_wdata),
        .req_lanes(req_lanes), .seq_addrs(seq_tab), .req_ready(req_ready),
        .rsp_valid(rsp_valid),
        .rsp_rdata(rdata), .rsp_data_ok(rsp_data_ok), .select_low_input(sel_lo),
        .select_high_input(sel_hi), .write_n(wr_n), .out_en_n(rd_en_n),
        .low_byte_strobe_n(lo_n), .high_byte_strobe_n(hi_n), .addr(pin_addr), .dq_out(dq_o),
        .dq_oe(dq_oe), .dq_in(dq_i), .hw_store_busy_n_out(bsy_out),
        .hw_store_busy_n_oe(bsy_oe), .hw_store_busy_n_in(bsy_n), .sleep_request_n(slp_n),
        .sleeping(sleeping));
    nvh_sram_model i_mem (.clk(clk), .reset(reset), .select_low_input(sel_lo),
        .select_high_input(sel_hi), .write_n(wr_n), .out_en_n(rd_en_n),
        .low_byte_strobe_n(lo_n), .high_byte_strobe_n(hi_n), .addr(pin_addr),
        .dq_out(dq_o), .seq_addrs(seq_tab), .hw_store_busy_n(bsy_n),
        .sleep_request_n(slp_n), .dq_in(dq_i), .dev_busy(dev_busy));
    // ****
    // shared tasks
    // ****
    task check(input [31:0] seen, input [31:0] exp);
        begin
            checks_done = checks_done + 1;
            if (seen !== exp) begin
                n_mismatch = n_mismatch + 1;
                $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
            end
        end
    endtask
    // one request; cyc holds edges from take to the completion pulse
    task req(input [2:0] op, input [19:0] a, input [15:0] d, input [1:0] ln);
        begin
            @(posedge clk);
            while (req_ready !== 1'b1) @(posedge clk);
            req_valid <= 1'b1;
            req_op    <= op;
            req_addr  <= a;
            req_wdata <= d;
            req_lanes <= ln;
            @(posedge clk);
            req_valid <= 1'b0;
            cyc = 0;
            while (rsp_valid !== 1'b1 && cyc < 400) begin
                @(posedge clk);
                cyc = cyc + 1;
            end
        end
    endtask
    task final_report;
        begin
            $display("checks %0d mismatches %0d", checks_done, n_mismatch);
            if (n_mismatch == 0 && checks_done > 0) $display("*** PASS ***");
            else $display("*** FAIL ***");
            $finish;
        end
    endtask
    // ****
    // scenarios
    // ****
    task t_rw;
        begin
            req(`NVH_OP_WRITE, 20'h0_0003, 16'hA5C3, 2'h3);
            req(`NVH_OP_WRITE, 20'h0_0003, 16'h1234, 2'h1);
            req(`NVH_OP_READ, 20'h0_0003, 16'h0000, 2'h0);
            check(rdata, 16'hA534);
            check(rsp_data_ok, 1'b1);
            check(cyc, 4);
            $display("test rw done");
        end
    endtask
    task t_store;
        begin
            req(`NVH_OP_HW_STORE, 20'h0_0000, 16'h0000, 2'h0);
            check(cyc >= 12 && cyc <= 24, 1'b1);
            req(`NVH_OP_HW_STORE, 20'h0_0000, 16'h0000, 2'h0);
            check(cyc <= 5, 1'b1);
            $display("test store done");
        end
    endtask
    task t_seq;
        integer lk;
        begin
            lk = lock_cyc;
            req(`NVH_OP_SW_SEQ, 20'h0_0000, 16'h0000, 2'h0);
            check(rsp_data_ok, 1'b0);
            check(lock_cyc > lk, 1'b1);
            req(`NVH_OP_READ, 20'h0_0003, 16'h0000, 2'h0);
            check(rdata, 16'hA534);
            $display("test sequence done");
        end
    endtask
    task t_sleep;
        begin
            req(`NVH_OP_SLEEP, 20'h0_0000, 16'h0000, 2'h0);
            check(sleeping, 1'b1);
            req(`NVH_OP_WAKE, 20'h0_0000, 16'h0000, 2'h0);
            check(sleeping, 1'b0);
            check(cyc >= 16, 1'b1);
            req(3'h7, 20'h0_0000, 16'h0000, 2'h0);
            check(cyc <= 2, 1'b1);
            $display("test sleep done");
        end
    endtask
    // a request offered while the enable is low must not be taken or move select or output enable
    task t_hold;
        begin
            @(posedge clk);
            clk_en    <= 1'b0;
            req_valid <= 1'b1;
            req_op    <= `NVH_OP_READ;
            req_addr  <= 20'h0_0003;
            repeat (4) @(posedge clk);
            check(req_ready, 1'b1);
            check(sel_lo, 1'b1);
            check(rd_en_n, 1'b1);
            req_valid <= 1'b0;
            clk_en    <= 1'b1;
            @(posedge clk);
            $display("test hold done");
        end
    endtask
    // hang guard: the whole run needs well under a thousand cycles
    always @(posedge clk) begin
        tick = tick + 1;
        if (tick == 5000) begin
            n_mismatch = n_mismatch + 1;
            final_report;
        end
    end
    initial begin
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        t_rw;
        t_store;
        t_seq;
        t_sleep;
        t_hold;
        final_report;
    end
endmodule // nvh_host_port_bench
